/* design/serial_adapter_pkg.sv */
// constants, register map and state types of the serial adapter control block
// assumes one 50 MHz clock and an axi4-lite master with 8-bit byte addresses
package serial_adapter_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] DATA_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] COMMAND_OFS = 8'h08;
   localparam logic [7:0] CONTROL_OFS = 8'h0c;
   localparam logic [7:0] COMMAND_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [4:0] COMMAND_SOFT_CLEAR = 5'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_ENABLE = 0;
   localparam int CMD_RX_IRQ_OFF = 1;
   localparam int CMD_ECHO = 4;
   localparam int CMD_PAR_EN = 5;
   localparam int CTL_STOP2 = 7;
   localparam int CTL_RX_SRC = 4;
   localparam logic [1:0] TXC_NO_RTS = 2'h0;
   localparam logic [1:0] TXC_IRQ_ON = 2'h1;
   localparam logic [1:0] TXC_BREAK = 2'h3;

   // ----------------------------------------------------------------
   // bit timing in 16x ticks
   // ----------------------------------------------------------------
   localparam logic [5:0] TICK_LAST = 6'h0f;
   localparam logic [5:0] START_CHECK_LAST = 6'h08;
   localparam logic [5:0] STOP_ONE_TICKS = 6'h10;
   localparam logic [5:0] STOP_HALF_TICKS = 6'h18;
   localparam logic [5:0] STOP_TWO_TICKS = 6'h20;
   localparam logic [3:0] FULL_WORD_BITS = 4'h8;
   localparam logic [3:0] SHORT_WORD_BITS = 4'h5;

   // crystal edges per 16x tick: documented divisor / 16, entry 0 is external x16
   localparam logic [11:0] DIV16_TABLE [16] = '{
      12'h001, 12'h900, 12'h600, 12'h418, 12'h358, 12'h300, 12'h180, 12'h0c0,
      12'h060, 12'h040, 12'h030, 12'h020, 12'h018, 12'h010, 12'h00c, 12'h006};

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} rx_state_e;

endpackage

/* design/async_serial_adapter_control.sv */
// control, status and serial engine of an asynchronous serial adapter
// assumes synchronous pins, an axi4-lite master and crystal_in_pin slower than clk/2
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module async_serial_adapter_control
   import serial_adapter_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic crystal_in_pin,
   input wire logic rx_clk_in,
   input wire logic rxd,
   output logic txd,
   input wire logic cts_n,
   input wire logic dcd_in,
   input wire logic dsr_in,
   output logic dtr_n,
   output logic rts_n,
   output logic irq_n
);

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic aw_full_reg, w_full_reg, w_lane_reg, bvalid_reg, rvalid_reg;
   logic [7:0] aw_addr_reg, w_data_reg, rdata_reg, rx_data_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [7:0] cmd_reg, ctl_reg, status_word;
   logic wr_go, wr_ok, rd_go, rd_map, status_rd, data_rd;
   logic wr_data, prog_rst, wr_cmd, wr_ctl;

   assign s_axi_awready = ~aw_full_reg;
   assign s_axi_wready = ~w_full_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = {24'h000000, rdata_reg};

   assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign wr_ok = wr_go & (aw_addr_reg[7:4] == 4'h0) & w_lane_reg;
   assign wr_data = wr_ok & (aw_addr_reg[7:2] == DATA_OFS[7:2]);
   assign prog_rst = wr_ok & (aw_addr_reg[7:2] == STATUS_OFS[7:2]);
   assign wr_cmd = wr_ok & (aw_addr_reg[7:2] == COMMAND_OFS[7:2]);
   assign wr_ctl = wr_ok & (aw_addr_reg[7:2] == CONTROL_OFS[7:2]);
   assign rd_go = s_axi_arvalid & ~rvalid_reg;
   assign rd_map = s_axi_araddr[7:4] == 4'h0;
   assign status_rd = rd_go & rd_map & (s_axi_araddr[7:2] == STATUS_OFS[7:2]);
   assign data_rd = rd_go & rd_map & (s_axi_araddr[7:2] == DATA_OFS[7:2]);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (aw_addr_reg[7:4] == 4'h0) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rresp_reg <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_map ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr[3:2])
            DATA_OFS[3:2]: rdata_reg <= rd_map ? rx_data_reg : 8'h00;
            STATUS_OFS[3:2]: rdata_reg <= rd_map ? status_word : 8'h00;
            COMMAND_OFS[3:2]: rdata_reg <= rd_map ? cmd_reg : 8'h00;
            default: rdata_reg <= rd_map ? ctl_reg : 8'h00;
         endcase
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cmd_reg <= COMMAND_RESET;
         ctl_reg <= CONTROL_RESET;
      end else if (prog_rst) begin
         cmd_reg[4:0] <= COMMAND_SOFT_CLEAR;
      end else begin
         if (wr_cmd) cmd_reg <= w_data_reg;
         if (wr_ctl) ctl_reg <= w_data_reg;
      end
   end

   // ----------------------------------------------------------------
   // baud generation and character format
   // ----------------------------------------------------------------
   logic xtal_prev_reg, rxc_prev_reg, tx_tick, rx_tick;
   logic [11:0] div_cnt_reg;
   logic [3:0] nbits;
   logic [5:0] stop_len;
   logic [7:0] data_mask;
   logic par_en, echo, rx_irq_en, tx_irq_en, brk;

   // external clock/16 at field 0, crystal divisors otherwise
   assign tx_tick = crystal_in_pin & ~xtal_prev_reg
      & (div_cnt_reg == DIV16_TABLE[ctl_reg[3:0]] - 12'h001);
   assign rx_tick = ctl_reg[CTL_RX_SRC] ? tx_tick : (rx_clk_in & ~rxc_prev_reg);
   assign nbits = FULL_WORD_BITS - {2'b00, ctl_reg[6:5]};
   assign data_mask = 8'hff >> ctl_reg[6:5];
   assign par_en = cmd_reg[CMD_PAR_EN];
   assign echo = cmd_reg[CMD_ECHO];
   assign stop_len = !ctl_reg[CTL_STOP2] ? STOP_ONE_TICKS
      : (nbits == SHORT_WORD_BITS && !par_en) ? STOP_HALF_TICKS : STOP_TWO_TICKS;
   assign rx_irq_en = cmd_reg[CMD_ENABLE] & ~cmd_reg[CMD_RX_IRQ_OFF];
   assign tx_irq_en = cmd_reg[CMD_ENABLE] & (cmd_reg[3:2] == TXC_IRQ_ON) & ~echo;
   assign brk = cmd_reg[3:2] == TXC_BREAK;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         xtal_prev_reg <= 1'b0;
         rxc_prev_reg <= 1'b0;
         div_cnt_reg <= 12'h000;
      end else begin
         xtal_prev_reg <= crystal_in_pin;
         rxc_prev_reg <= rx_clk_in;
         if (tx_tick) div_cnt_reg <= 12'h000;
         else if (crystal_in_pin && !xtal_prev_reg) div_cnt_reg <= div_cnt_reg + 12'h001;
      end
   end

   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
      case (mode)
         2'h0: par_bit = ~^d;
         2'h1: par_bit = ^d;
         2'h2: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // transmitter
   // ----------------------------------------------------------------
   tx_state_e tx_state_reg;
   logic [5:0] tx_cnt_reg;
   logic [2:0] tx_bit_reg;
   logic [7:0] tx_hold_reg, tx_shift_reg;
   logic tx_empty_reg, tx_line_reg, tx_par_reg, tx_halt_reg, tx_take;
   logic [7:0] echo_sh_reg;

   assign tx_take = tx_tick & (tx_state_reg == TX_IDLE) & ~tx_empty_reg & ~tx_halt_reg & ~brk;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_state_reg <= TX_IDLE;
         tx_cnt_reg <= 6'h00;
         tx_bit_reg <= 3'h0;
         tx_hold_reg <= 8'h00;
         tx_shift_reg <= 8'h00;
         tx_empty_reg <= 1'b1;
         tx_line_reg <= 1'b1;
         tx_par_reg <= 1'b0;
         tx_halt_reg <= 1'b1;
      end else begin
         // stop only once holding and shift register are both empty
         if (cmd_reg[CMD_ENABLE]) tx_halt_reg <= 1'b0;
         else if (tx_empty_reg && tx_state_reg == TX_IDLE) tx_halt_reg <= 1'b1;
         if (tx_tick) begin
            tx_cnt_reg <= tx_cnt_reg + 6'h01;
            case (tx_state_reg)
               TX_IDLE: begin
                  tx_cnt_reg <= 6'h00;
                  tx_line_reg <= ~(brk & tx_empty_reg);
                  if (tx_take) begin
                     tx_shift_reg <= tx_hold_reg & data_mask;
                     tx_par_reg <= par_bit(tx_hold_reg & data_mask, cmd_reg[7:6]);
                     tx_empty_reg <= 1'b1;
                     tx_line_reg <= 1'b0;
                     tx_state_reg <= TX_START;
                  end
               end
               TX_START: if (tx_cnt_reg == TICK_LAST) begin
                  tx_cnt_reg <= 6'h00;
                  tx_bit_reg <= 3'h0;
                  tx_line_reg <= tx_shift_reg[0];
                  tx_state_reg <= TX_DATA;
               end
               TX_DATA: if (tx_cnt_reg == TICK_LAST) begin
                  tx_cnt_reg <= 6'h00;
                  tx_shift_reg <= tx_shift_reg >> 1;
                  tx_bit_reg <= tx_bit_reg + 3'h1;
                  tx_line_reg <= tx_shift_reg[1];
                  if ({1'b0, tx_bit_reg} == nbits - 4'h1) begin
                     tx_line_reg <= par_en ? tx_par_reg : 1'b1;
                     tx_state_reg <= par_en ? TX_PAR : TX_STOP;
                  end
               end
               TX_PAR: if (tx_cnt_reg == TICK_LAST) begin
                  tx_cnt_reg <= 6'h00;
                  tx_line_reg <= 1'b1;
                  tx_state_reg <= TX_STOP;
               end
               TX_STOP: if (tx_cnt_reg == stop_len - 6'h01) tx_state_reg <= TX_IDLE;
               default: tx_state_reg <= TX_IDLE;
            endcase
         end
         if (wr_data) begin
            tx_hold_reg <= w_data_reg;
            tx_empty_reg <= 1'b0;
         end
      end
   end

   // echo path: rxd delayed by eight 16x ticks, txd held high while cts_n is high
   always_ff @(posedge clk) begin
      if (!nrst) begin
         echo_sh_reg <= 8'hff;
         txd <= 1'b1;
      end else begin
         if (rx_tick) echo_sh_reg <= {echo_sh_reg[6:0], rxd};
         txd <= cts_n ? 1'b1 : (echo ? echo_sh_reg[7] : tx_line_reg);
      end
   end

   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   rx_state_e rx_state_reg;
   logic [5:0] rx_cnt_reg;
   logic [2:0] rx_bit_reg;
   logic [7:0] rx_sh_reg, rx_word;
   logic rx_par_reg, rx_full_reg, par_err_reg, frm_err_reg, ovr_reg, rx_deliver;

   assign rx_deliver = rx_tick & (rx_state_reg == RX_STOP) & (rx_cnt_reg == TICK_LAST);
   assign rx_word = rx_sh_reg >> ctl_reg[6:5];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_state_reg <= RX_IDLE;
         rx_cnt_reg <= 6'h00;
         rx_bit_reg <= 3'h0;
         rx_sh_reg <= 8'h00;
         rx_par_reg <= 1'b0;
      end else if (rx_tick) begin
         rx_cnt_reg <= rx_cnt_reg + 6'h01;
         case (rx_state_reg)
            RX_IDLE: begin
               rx_cnt_reg <= 6'h00;
               if (!rxd && cmd_reg[CMD_ENABLE]) rx_state_reg <= RX_START;
            end
            RX_START: if (rxd) begin
               rx_state_reg <= RX_IDLE;
            end else if (rx_cnt_reg == START_CHECK_LAST) begin
               rx_cnt_reg <= 6'h00;
               rx_bit_reg <= 3'h0;
               rx_state_reg <= RX_DATA;
            end
            RX_DATA: if (rx_cnt_reg == TICK_LAST) begin
               rx_cnt_reg <= 6'h00;
               rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
               rx_bit_reg <= rx_bit_reg + 3'h1;
               if ({1'b0, rx_bit_reg} == nbits - 4'h1)
                  rx_state_reg <= par_en ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (rx_cnt_reg == TICK_LAST) begin
               rx_cnt_reg <= 6'h00;
               rx_par_reg <= rxd;
               rx_state_reg <= RX_STOP;
            end
            RX_STOP: if (rx_cnt_reg == TICK_LAST) rx_state_reg <= rxd ? RX_IDLE : RX_WAIT;
            RX_WAIT: if (rxd) rx_state_reg <= RX_IDLE;
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_data_reg <= 8'h00;
         rx_full_reg <= 1'b0;
         par_err_reg <= 1'b0;
         frm_err_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end else begin
         if (data_rd) begin
            rx_full_reg <= 1'b0;
            ovr_reg <= 1'b0;
         end
         if (prog_rst) ovr_reg <= 1'b0;
         if (rx_deliver) begin
            if (rx_full_reg && !data_rd) begin
               ovr_reg <= 1'b1;
            end else begin
               rx_data_reg <= rx_word;
               rx_full_reg <= 1'b1;
               frm_err_reg <= ~rxd;
               par_err_reg <= par_en & ~cmd_reg[7]
                  & (rx_par_reg != par_bit(rx_word, cmd_reg[7:6]));
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt and modem status
   // ----------------------------------------------------------------
   logic data_irq_reg, modem_pend_reg, dcd_st_reg, dsr_st_reg, rx_evt, tx_evt;

   assign rx_evt = rx_deliver & rx_irq_en;
   assign tx_evt = tx_take & tx_irq_en;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         data_irq_reg <= 1'b0;
      end else begin
         if (status_rd) data_irq_reg <= 1'b0;
         if (rx_evt || tx_evt) data_irq_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         modem_pend_reg <= 1'b0;
         dcd_st_reg <= 1'b0;
         dsr_st_reg <= 1'b0;
      end else if (prog_rst || !cmd_reg[CMD_ENABLE]) begin
         modem_pend_reg <= 1'b0;
         dcd_st_reg <= dcd_in;
         dsr_st_reg <= dsr_in;
      end else if (status_rd) begin
         modem_pend_reg <= 1'b0;
      end else if (!modem_pend_reg && (dcd_in != dcd_st_reg || dsr_in != dsr_st_reg)) begin
         modem_pend_reg <= 1'b1;
         dcd_st_reg <= dcd_in;
         dsr_st_reg <= dsr_in;
      end
   end

   assign status_word = {data_irq_reg | modem_pend_reg, dsr_st_reg, dcd_st_reg,
      tx_empty_reg & ~cts_n, rx_full_reg, ovr_reg, frm_err_reg, par_err_reg};
   assign irq_n = ~(data_irq_reg | modem_pend_reg);
   assign dtr_n = ~cmd_reg[CMD_ENABLE];
   assign rts_n = ~echo & (cmd_reg[3:2] == TXC_NO_RTS);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_status_read_clears:
      assert property (@(posedge clk) disable iff (!nrst)
         status_rd && !rx_evt && !tx_evt |=> irq_n && !status_word[7])
      else $error("interrupt not cleared by status read");
   a_modem_rearm:
      assert property (@(posedge clk) disable iff (!nrst)
         cmd_reg[CMD_ENABLE] && !modem_pend_reg && !status_rd && !prog_rst
         && dcd_in != dcd_st_reg |=> !irq_n)
      else $error("modem change did not raise interrupt");
   a_rx_full_set:
      assert property (@(posedge clk) disable iff (!nrst)
         rx_deliver && !rx_full_reg |=> rx_full_reg && rx_data_reg == $past(rx_word))
      else $error("received character not stored");
   a_tx_empty_take:
      assert property (@(posedge clk) disable iff (!nrst)
         tx_take && !wr_data |=> tx_empty_reg ##0 tx_state_reg == TX_START)
      else $error("transmit register not freed");
   a_prog_reset:
      assert property (@(posedge clk) disable iff (!nrst)
         prog_rst |=> dtr_n && !ovr_reg ##1 !modem_pend_reg)
      else $error("programmed reset effects missing");
   a_echo_rts:
      assert property (@(posedge clk) disable iff (!nrst) echo |-> !rts_n)
      else $error("rts not low in echo mode");
   a_disable_quiet:
      assert property (@(posedge clk) disable iff (!nrst)
         !cmd_reg[CMD_ENABLE] && irq_n && !prog_rst |=> irq_n)
      else $error("interrupt raised while disabled");
   a_false_start:
      assert property (@(posedge clk) disable iff (!nrst)
         rx_tick && rx_state_reg == RX_START && rxd |=> rx_state_reg == RX_IDLE)
      else $error("false start not rejected");
   a_odd_parity:
      assert property (@(posedge clk) disable iff (!nrst)
         tx_take && cmd_reg[7:5] == 3'h1 |=> ^{tx_shift_reg, tx_par_reg})
      else $error("odd parity wrong");
   a_echo_delay:
      assert property (@(posedge clk) disable iff (!nrst)
         echo && !cts_n |=> txd == $past(echo_sh_reg[7]))
      else $error("echo path wrong");

endmodule // async_serial_adapter_control
`default_nettype wire

/* sim/serial_modem_model.sv */
// -----------------------------------------------
// modem side of the serial adapter: crystal, lines, receive frames
// -----------------------------------------------
// assumes 1 ns units; crystal edges fall on clk falling edges, between rising ones
`timescale 1ns/100ps
`default_nettype none
module serial_modem_model (
   output logic crystal_in_pin,
   output logic rx_clk_in,
   output logic rxd,
   output logic dcd_in,
   output logic dsr_in,
   output logic cts_n
);
   assign rx_clk_in = crystal_in_pin;
   initial begin
      crystal_in_pin = 1'b0;
      rxd = 1'b1;
      dcd_in = 1'b0;
      dsr_in = 1'b0;
      cts_n = 1'b0;
      forever #40 crystal_in_pin = ~crystal_in_pin;
   end
   // start, eight data lsb first, odd parity, stop; one bit is 16 crystal periods
   task automatic send_byte(input logic [7:0] d);
      logic [10:0] f;
      // keep line changes clear of the clk edges
      #5;
      f = {1'b1, ~^d, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd = f[i];
         #1280;
      end
   endtask
   // low for 4 ticks only, well inside the start check
   task automatic false_start();
      #5;
      rxd = 1'b0;
      #320;
      rxd = 1'b1;
      #1280;
   endtask
endmodule // serial_modem_model
`default_nettype wire

/* sim/async_serial_adapter_control_tb.sv */
// -----------------------------------------------
// self-checking bench of the serial adapter control block
// -----------------------------------------------
// assumes the modem model drives the serial side
`timescale 1ns/100ps
`default_nettype none
module async_serial_adapter_control_tb;
   import serial_adapter_pkg::*;
   logic clk = 1'b0, nrst = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic crystal_in_pin, rx_clk_in, rxd, txd, cts_n, dcd_in, dsr_in, dtr_n, rts_n, irq_n;
   int err_count = 0, checked = 0;
   logic [7:0] rd;
   logic [1:0] rs;
   serial_modem_model modem (.crystal_in_pin, .rx_clk_in, .rxd, .dcd_in, .dsr_in, .cts_n);
   async_serial_adapter_control DUT (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .crystal_in_pin, .rx_clk_in, .rxd, .txd, .cts_n, .dcd_in,
      .dsr_in, .dtr_n, .rts_n, .irq_n);
   initial forever #10 clk = ~clk;
   // -----------------------------------------------
   // bus and check helpers
   // -----------------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (e !== g) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (s_axi_awvalid || s_axi_wvalid) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         #1;
      end
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdreg(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_irq(input logic lvl);
      for (int i = 0; i < 20 && irq_n !== lvl; i++) @(posedge clk);
   endtask
   // -----------------------------------------------
   // scenarios
   // -----------------------------------------------
   task automatic t_reset();
      rdreg(STATUS_OFS);
      chk("status", 16'h10, {8'h0, rd});
      chk("lines", 16'h7, {rts_n, dtr_n, irq_n});
      $display("test reset done");
   endtask
   task automatic t_tx();
      logic [9:0] f;
      wr(COMMAND_OFS, 8'h21);
      wr(DATA_OFS, 8'h5a);
      for (int i = 0; i < 400 && txd !== 1'b0; i++) @(posedge clk);
      repeat (32) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (64) @(posedge clk);
         f[i] = txd;
      end
      chk("tx frame", {6'h0, 1'b1, ~^8'h5a, 8'h5a}, {6'h0, f});
      $display("test transmit done");
   endtask
   task automatic t_rx();
      modem.send_byte(8'hc3);
      wait_irq(1'b0);
      rdreg(STATUS_OFS);
      chk("status full", 16'h98, {8'h0, rd});
      rdreg(STATUS_OFS);
      chk("status again", 16'h18, {8'h0, rd});
      rdreg(DATA_OFS);
      chk("rx data", 16'hc3, {8'h0, rd});
      modem.false_start();
      repeat (800) @(posedge clk);
      rdreg(STATUS_OFS);
      chk("false start", 16'h10, {8'h0, rd});
      $display("test receive done");
   endtask
   task automatic t_modem();
      modem.dcd_in <= 1'b1;
      wait_irq(1'b0);
      chk("irq dcd", 16'h0, {15'h0, irq_n});
      rdreg(STATUS_OFS);
      chk("status dcd", 16'hb0, {8'h0, rd});
      modem.dsr_in <= 1'b1;
      wait_irq(1'b0);
      wr(STATUS_OFS, 8'h00);
      chk("prog reset", 16'h3, {dtr_n, irq_n});
      rdreg(COMMAND_OFS);
      chk("command", 16'h20, {8'h0, rd});
      modem.dsr_in <= 1'b0;
      repeat (10) @(posedge clk);
      rdreg(STATUS_OFS);
      chk("track", 16'h130, {7'h0, irq_n, rd});
      rdreg(8'h40);
      chk("unmapped", {14'h0, RESP_SLVERR}, {14'h0, rs});
      wr(COMMAND_OFS, 8'h11);
      chk("echo rts", 16'h1, {15'h0, txd & ~rts_n});
      $display("test modem done");
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_tx();
      t_rx();
      t_modem();
      print_verdict();
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      print_verdict();
   end
endmodule // async_serial_adapter_control_tb
`default_nettype wire
